/* File: verilog/lfs_supervisor.sv */
`timescale 1ns/10ps
module lfs_supervisor
  import lfs_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // pins from outside
  input  wire logic       enable,
  input  wire lfs_flags_t flagsIn,
  input  wire logic       extOscIn,
  input  wire logic       groundShortTimerCap,
  input  wire logic       dimmingThresholdIn,
  input  wire logic       daytimeForceOn,
  // open-drain fault pins, oe low means pulled low
  output logic            generalFaultOut,
  output logic            generalFaultOe,
  output logic            stringFaultOut,
  output logic            stringFaultOe,
  // converter control
  output logic            softStartRun,
  output logic            switchEnable,
  output logic            switchTick,
  output logic            extOscSelected,
  output logic            dimmingPulseOut,
  output logic            regulatorOn
);

  // -------------------------------------------------------------------------
  // synchronisers
  // -------------------------------------------------------------------------
  localparam int unsigned NSYNC = 12;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] synIn;
  lfs_flags_t       flg;
  logic             enS;
  logic             extS;
  logic             rampS;
  logic             dimThS;
  logic             dayS;

  assign rawIn = {flagsIn, enable, extOscIn, groundShortTimerCap,
                  dimmingThresholdIn, daytimeForceOn};

  lfs_sync2 #(.W(NSYNC)) uSync (
    .mclk (mclk),
    .rst  (rst),
    .din  (rawIn),
    .dout (synIn)
  );

  assign flg    = synIn[11:5];
  assign enS    = synIn[4];
  assign extS   = synIn[3];
  assign rampS  = synIn[2];
  assign dimThS = synIn[1];
  assign dayS   = synIn[0];

  // -------------------------------------------------------------------------
  // edge detection
  // -------------------------------------------------------------------------
  logic enPrev_q;
  logic extPrev_q;
  logic rampPrev_q;
  logic extRise;
  logic rampRise;
  logic enRise;
  logic enFall;

  always_ff @(posedge mclk) begin
    if (rst) begin
      enPrev_q   <= 1'b0;
      extPrev_q  <= 1'b0;
      rampPrev_q <= 1'b0;
    end else begin
      enPrev_q   <= enS;
      extPrev_q  <= extS;
      rampPrev_q <= rampS;
    end
  end

  assign extRise  = extS && !extPrev_q;
  assign rampRise = rampS && !rampPrev_q;
  assign enRise   = enS && !enPrev_q;
  assign enFall   = !enS && enPrev_q;

  // -------------------------------------------------------------------------
  // oscillator selection
  // -------------------------------------------------------------------------
  localparam logic [10:0] OSC_WAIT_W = 11'(OSC_WAIT_CYC);
  localparam logic [6:0]  DIV_LAST   = 7'(INT_OSC_DIV - 1);
  logic [10:0] idle_q;
  logic [10:0] idle_d;
  logic        extSel_q;
  logic        extSel_d;
  logic [6:0]  div_q;
  logic [6:0]  div_d;
  logic        intTick;
  logic        swTick;

  // a rising edge on the external oscillator input restarts the idle wait
  assign idle_d   = extRise ? OCNT_W0 :
                    (idle_q != OSC_WAIT_W) ? idle_q + 11'h001 : idle_q;
  assign extSel_d = extRise ? 1'b1 :
                    (!extS && idle_q == OSC_WAIT_W) ? 1'b0 :
                    extSel_q;
  assign intTick  = !extSel_q && div_q == DIV_LAST;
  assign div_d    = (extSel_q || div_q == DIV_LAST) ? DCNT_W0 :
                    div_q + 7'h01;
  assign swTick   = extSel_q ? extRise : intTick;

  always_ff @(posedge mclk) begin
    if (rst) begin
      idle_q   <= OSC_WAIT_W;
      extSel_q <= 1'b0;
      div_q    <= DCNT_W0;
    end else begin
      idle_q   <= idle_d;
      extSel_q <= extSel_d;
      div_q    <= div_d;
    end
  end

  // -------------------------------------------------------------------------
  // dimming pulse
  // -------------------------------------------------------------------------
  logic dimPulse;
  assign dimPulse = dayS | dimThS;

  // -------------------------------------------------------------------------
  // shutdown and latches
  // -------------------------------------------------------------------------
  lfs_state_t state_q;
  lfs_state_t state_d;
  lfs_latch_t lat_q;
  lfs_latch_t lat_d;
  logic       hardOff;
  logic       latClear;
  logic       active;
  logic       gndExp;
  logic       shortExp;
  logic       openDet;
  logic       ssStop;

  assign hardOff  = flg.undervoltage_lockout || flg.overTemp;
  assign latClear = flg.undervoltage_lockout || enRise || enFall;
  assign active   = state_q == ST_RUN;
  assign openDet  = flg.fbLow && flg.ovpOpen;

  lfs_edge_count #(.W(4), .TERM(GSHORT_COUNTS)) uGnd (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (latClear),
    .run     (active && flg.fbLow),
    .tick    (rampRise),
    .expired (gndExp)
  );

  lfs_edge_count #(.W(16), .TERM(SSHORT_COUNTS)) uShort (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (latClear),
    .run     (active && flg.strShort),
    .tick    (swTick && dimPulse),
    .expired (shortExp)
  );

  // a new detection wins over the clear in the same cycle
  assign lat_d = '{
    gndShort: (active && gndExp) || (lat_q.gndShort && !latClear),
    openStr:  (active && openDet) || (lat_q.openStr && !latClear),
    strShort: (active && shortExp) || (lat_q.strShort && !latClear)
  };

  always_comb begin
    case (state_q)
      ST_OFF:  state_d = (enS && !hardOff) ? ST_RUN : ST_OFF;
      ST_RUN:  state_d = !enS ? ST_OFF :
                         (hardOff || lat_d != '0) ? ST_HLD : ST_RUN;
      ST_HLD:  state_d = !enS ? ST_OFF :
                         (!hardOff && lat_d == '0) ? ST_RUN : ST_HLD;
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_OFF;
      lat_q   <= '0;
    end else begin
      state_q <= state_d;
      lat_q   <= lat_d;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  logic runNext;
  logic genFault;
  logic strFault;

  assign ssStop   = flg.overCurr || flg.overVolt;
  assign runNext  = state_d == ST_RUN;
  assign genFault = flg.undervoltage_lockout || flg.overTemp || flg.overVolt ||
                    lat_d.gndShort;
  assign strFault = lat_d.openStr || lat_d.strShort;

  always_ff @(posedge mclk) begin
    if (rst) begin
      generalFaultOut <= 1'b0;
      generalFaultOe  <= 1'b1;
      stringFaultOut  <= 1'b0;
      stringFaultOe   <= 1'b1;
      softStartRun    <= 1'b0;
      switchEnable    <= 1'b0;
      switchTick      <= 1'b0;
      extOscSelected  <= 1'b0;
      dimmingPulseOut <= 1'b0;
      regulatorOn     <= 1'b0;
    end else begin
      generalFaultOe  <= !genFault;
      stringFaultOe   <= !strFault;
      // released ramp restarts from zero on recovery
      softStartRun    <= runNext && !ssStop;
      switchEnable    <= runNext && !ssStop;
      switchTick      <= swTick && runNext && !ssStop;
      extOscSelected  <= extSel_d;
      dimmingPulseOut <= runNext && dimPulse;
      regulatorOn     <= enS;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  sequence s_gndLatch;
    active && gndExp;
  endsequence

  a_general_fault_heat: assert property (@(posedge mclk) disable iff (rst)
    flg.overTemp |=> !generalFaultOe)
    else $error("general fault not pulled on overtemperature");

  a_string_fault_open: assert property (@(posedge mclk) disable iff (rst)
    (active && openDet) |=> !stringFaultOe)
    else $error("string fault not pulled on open string");

  a_lockout_stops: assert property (@(posedge mclk) disable iff (rst)
    flg.undervoltage_lockout |=> !switchEnable && !softStartRun)
    else $error("switching during lockout");

  a_heat_stops: assert property (@(posedge mclk) disable iff (rst)
    flg.overTemp |=> !switchEnable)
    else $error("switching during overtemperature");

  a_overcurrent_stop: assert property (@(posedge mclk) disable iff (rst)
    flg.overCurr |=> !switchEnable && !softStartRun)
    else $error("switching during overcurrent");

  a_overvolt_stop: assert property (@(posedge mclk) disable iff (rst)
    flg.overVolt |=> !softStartRun)
    else $error("soft start not discharged on overvoltage");

  a_auto_restart: assert property (@(posedge mclk) disable iff (rst)
    (active && $fell(ssStop) && !hardOff && enS && lat_q == '0 &&
     !ssStop && lat_d == '0) |=> softStartRun)
    else $error("no restart after protection clears");

  a_gnd_latch: assert property (@(posedge mclk) disable iff (rst)
    s_gndLatch |=> lat_q.gndShort ##0 !generalFaultOe)
    else $error("ground short not latched");

  a_latch_hold: assert property (@(posedge mclk) disable iff (rst)
    (lat_q.strShort && !latClear) |=> lat_q.strShort)
    else $error("string short latch dropped");

  a_force_on: assert property (@(posedge mclk) disable iff (rst)
    (dayS && runNext) |=> dimmingPulseOut)
    else $error("force-on not driving dimming pulse");

  a_ext_priority: assert property (@(posedge mclk) disable iff (rst)
    extRise |=> extOscSelected)
    else $error("external oscillator not selected");

  a_overvolt_fault: assert property (@(posedge mclk) disable iff (rst)
    flg.overVolt |=> !generalFaultOe)
    else $error("general fault not pulled on overvoltage");

  a_string_fault_short: assert property (@(posedge mclk) disable iff (rst)
    (active && shortExp) |=> !stringFaultOe)
    else $error("string fault not pulled on string short");

  a_lockout_clears: assert property (@(posedge mclk) disable iff (rst)
    (flg.undervoltage_lockout && !active) |=> lat_q == '0)
    else $error("latch kept through lockout");

  a_gnd_count_clear: assert property (@(posedge mclk) disable iff (rst)
    !flg.fbLow |=> !gndExp)
    else $error("ground-short counter not cleared");

  a_short_count_clear: assert property (@(posedge mclk) disable iff (rst)
    !flg.strShort |=> !shortExp)
    else $error("short counter not cleared");

  a_start_with_en: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_OFF && enS && !hardOff && !ssStop) |=>
      switchEnable && softStartRun)
    else $error("no start with enable");

  a_tick_gated: assert property (@(posedge mclk) disable iff (rst)
    switchTick |-> switchEnable)
    else $error("switching tick while stopped");

  a_internal_base: assert property (@(posedge mclk) disable iff (rst)
    (!extS && idle_q == OSC_WAIT_W) |=> !extOscSelected)
    else $error("internal oscillator not restarted");

  a_regulator_kept: assert property (@(posedge mclk) disable iff (rst)
    (flg.undervoltage_lockout && enS) |=> regulatorOn)
    else $error("regulator dropped during lockout");

endmodule : lfs_supervisor

/* File: verilog/lfs_pkg.sv */
package lfs_pkg;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ     = 25_000_000;
  localparam int unsigned OSC_WAIT_US     = 30;
  localparam int unsigned OSC_WAIT_CYC    =
    (OSC_WAIT_US * (CLK_FREQ_HZ / 1_000_000) < 1) ? 1 :
     OSC_WAIT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned GSHORT_COUNTS   = 8;
  localparam int unsigned SSHORT_COUNTS   = 32770;
  localparam int unsigned INT_OSC_DIV     = 84;

  localparam logic [3:0]  GCNT_W0         = 4'h0;
  localparam logic [15:0] SCNT_W0         = 16'h0000;
  localparam logic [10:0] OCNT_W0         = 11'h000;
  localparam logic [6:0]  DCNT_W0         = 7'h00;

  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic undervoltage_lockout;
    logic overTemp;
    logic overVolt;
    logic overCurr;
    logic fbLow;
    logic ovpOpen;
    logic strShort;
  } lfs_flags_t;

  typedef struct packed {
    logic gndShort;
    logic openStr;
    logic strShort;
  } lfs_latch_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_HLD = 3'b100
  } lfs_state_t;

endpackage : lfs_pkg

/* File: verilog/lfs_sync2.sv */
`timescale 1ns/10ps
module lfs_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : lfs_sync2

/* File: verilog/lfs_edge_count.sv */
`timescale 1ns/10ps
module lfs_edge_count
  import lfs_pkg::*;
#(
  parameter int unsigned W    = 4,
  parameter int unsigned TERM = 8
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // control
  input  wire logic clear,
  input  wire logic run,
  input  wire logic tick,
  // result
  output logic      expired
);
  localparam logic [W-1:0] TERM_W = W'(TERM);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (rst || clear || !run) begin
      cnt_q   <= '0;
      expired <= 1'b0;
    end else if (tick && cnt_q != TERM_W) begin
      cnt_q   <= cnt_q + W'(1);
      expired <= (cnt_q + W'(1)) == TERM_W;
    end
  end
endmodule : lfs_edge_count

/* File: sim/lfs_host_model.sv */
`timescale 1ns/10ps
module lfs_host_model (
  // clock
  input  wire logic mclk,
  // requests from bench
  input  wire logic enReq,
  input  wire logic supplyOk,
  input  wire logic forceReq,
  // fault pin drivers
  input  wire logic genOe,
  input  wire logic genOut,
  input  wire logic strOe,
  input  wire logic strOut,
  // pins
  output logic      enable,
  output logic      daytimeForceOn,
  output logic      genPin,
  output logic      strPin
);
  logic forceSeen_q;
  // pull-ups on both open-drain lines
  assign genPin = genOe ? 1'b1 : genOut;
  assign strPin = strOe ? 1'b1 : strOut;
  initial begin
    enable = 1'b0;
    daytimeForceOn = 1'b0;
    forceSeen_q = 1'b0;
  end
  always @(posedge mclk) begin
    daytimeForceOn <= forceReq;
    forceSeen_q <= daytimeForceOn;
    // enable only on supply and a settled force-on level
    if (!enReq) begin
      enable <= 1'b0;
    end else if (supplyOk && forceSeen_q == daytimeForceOn) begin
      enable <= 1'b1;
    end
  end
endmodule : lfs_host_model

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import lfs_pkg::*;
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] val;
  } lfs_note_t;
  localparam logic [7:0] G = 8'h01, S = 8'h02, SS = 8'h04, SW = 8'h08;
  localparam logic [7:0] X = 8'h10, D = 8'h20, R = 8'h40, GP = 8'h80;
  logic mclk = 0, rst = 1, enReq = 0, supplyOk = 0, forceReq = 0;
  logic extOscIn = 0, capIn = 0, dimIn = 0, extRun = 0, rndOn = 0;
  logic enable, dayOn, genPin, strPin, gOut, gOe, sOut, sOe;
  logic ssRun, swEn, swTick, extSel, dimOut, regOn;
  lfs_flags_t flags = '0;
  logic [7:0] obs;
  logic [31:0] r;
  lfs_note_t notes[$];
  lfs_note_t n;
  int err_total = 0, compares = 0, cycles = 0, seed, k;
  event chk;
  assign obs = {genPin, regOn, dimOut, extSel, swEn, ssRun, sOe, gOe};
  always #20 mclk = ~mclk;
  lfs_supervisor dut (
    .mclk(mclk), .rst(rst), .enable(enable), .flagsIn(flags),
    .extOscIn(extOscIn), .groundShortTimerCap(capIn),
    .dimmingThresholdIn(dimIn), .daytimeForceOn(dayOn),
    .generalFaultOut(gOut), .generalFaultOe(gOe),
    .stringFaultOut(sOut), .stringFaultOe(sOe),
    .softStartRun(ssRun), .switchEnable(swEn), .switchTick(swTick),
    .extOscSelected(extSel), .dimmingPulseOut(dimOut),
    .regulatorOn(regOn)
  );
  lfs_host_model host (
    .mclk(mclk), .enReq(enReq), .supplyOk(supplyOk),
    .forceReq(forceReq), .genOe(gOe), .genOut(gOut), .strOe(sOe),
    .strOut(sOut), .enable(enable), .daytimeForceOn(dayOn),
    .genPin(genPin), .strPin(strPin)
  );
  // -------------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------------
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic check(input logic [7:0] m, input logic [7:0] v);
    notes.push_back('{m, v});
    ->chk;
  endtask : check
  task automatic setEn(input logic b);
    enReq = b;
    cyc(8);
  endtask : setEn
  task automatic ramp(input int c);
    repeat (c) begin
      capIn = 1'b1;
      cyc(3);
      capIn = 1'b0;
      cyc(3);
    end
  endtask : ramp
  task automatic test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // -------------------------------------------------------------------------
  // monitor and background stimulus
  // -------------------------------------------------------------------------
  always @(chk) begin
    n = notes.pop_front();
    compares++;
    if ((obs & n.mask) !== n.val) begin
      err_total++;
      $display("Error outputs mask %h expected %h seen %h", n.mask, n.val,
               obs & n.mask);
    end
  end
  always begin
    @(posedge mclk);
    #1;
    cycles++;
    r = $random(seed);
    extOscIn = extRun & cycles[1];
    if (rndOn) begin
      dimIn = r[0];
    end
    if (cycles == 6000) begin
      err_total++;
      test_done;
    end
  end
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    seed = 32'hc8ab;
    cyc(20);
    rst = 1'b0;
    cyc(2);
    check(8'hff, GP | S | G);
    supplyOk = 1'b1;
    setEn(1'b1);
    check(8'hff, GP | R | SW | SS | S | G);
    for (k = 4; k <= 6; k++) begin
      flags = lfs_flags_t'(7'h01 << k);
      cyc(6);
      check(GP | R | SW | SS | G, R);
      flags = '0;
      cyc(8);
      if (k != 6) check(SW | SS | G, SW | SS | G);
    end
    setEn(1'b0);
    setEn(1'b1);
    flags.overCurr = 1'b1;
    cyc(6);
    check(SW | SS | G, G);
    flags = '0;
    cyc(8);
    check(SW | SS, SW | SS);
    flags.fbLow = 1'b1;
    ramp(1 + ($unsigned($random(seed)) % 7));
    flags = '0;
    cyc(6);
    flags.fbLow = 1'b1;
    ramp(7);
    check(G | SW, G | SW);
    ramp(1);
    cyc(2);
    check(GP | G | SW, 8'h00);
    flags = '0;
    cyc(8);
    check(G, 8'h00);
    setEn(1'b0);
    setEn(1'b1);
    check(G | SW, G | SW);
    flags = lfs_flags_t'(7'h06);
    cyc(6);
    check(S | SW, 8'h00);
    flags = lfs_flags_t'(7'h40);
    cyc(6);
    flags = '0;
    cyc(8);
    check(S, S);
    setEn(1'b0);
    setEn(1'b1);
    flags.strShort = 1'b1;
    rndOn = 1'b1;
    extRun = 1'b1;
    cyc(200);
    check(X | S, X | S);
    flags = '0;
    cyc(8);
    extRun = 1'b0;
    rndOn = 1'b0;
    cyc(10);
    check(X, X);
    cyc(760);
    check(X, 8'h00);
    forceReq = 1'b1;
    cyc(8);
    check(D, D);
    cyc(4);
    test_done;
  end
endmodule : tb_top
